// [rtl/tzs_supervisor.sv]
// Thermal zone supervisor: secondary status, tach modes, auto low-limit adjust and thermal trip.
// Assumes readings, monitor strobe, lock and global enable come from logic on the same clock;
// main_power_good is an asynchronous pin.
`timescale 1ns/1ps
`include "tzs_params.svh"

// Summary of operation
// - Status one bits 6:4 clear by one-write, event ended
// - Secondary status never raises an interrupt
// - Power good rise restores secondary status defaults
// - Status two, three: one-write clears ended events
// - Two-bit mode per tach in bits 7:2
// - Mode bits 1:0 ignore writes, read zero
// - Lock blocks writes to top, trip and adjust registers, not low limits
// - Top compare only when zone adjust enabled
// - Reaching top subtracts step 2..8 from low
// - Ambient zone step and delay in own register
// - Wait programmed 1..4 minutes between adjustments
// - Enable bits 3:1 select zones one to three
// - Interrupt needs top enable, status and global enable
// - Set top status when reading exceeds top
// - Top status stays until one-write and condition gone
// - Power good rise clears top status
// - Control bit 1 enables trip output
// - Trip limit separate from high limit
// - Trip sets status; output needs zone enable
// - Two consecutive exceeding cycles before trip
// - Trip status clears by one-write when inactive
module tzs_supervisor
  import tzs_pkg::*;
#(
  parameter logic [35:0] MINUTE_CYCLES = 36'(`TZS_MINUTE_S * `TZS_CLK_HZ) // Cycles in one minute
) (
  input  wire logic            clock,            // 200 MHz monitor clock
  input  wire logic            nrst,             // Synchronous reset, low active
  input  wire tzs_pkg::tzs_byte_t reg_addr,      // Register address
  input  wire tzs_pkg::tzs_byte_t reg_wdata,     // Write data
  input  wire logic            reg_wr,           // Write strobe
  input  wire logic            reg_rd,           // Read strobe
  output      tzs_pkg::tzs_byte_t reg_rdata,     // Read data, one cycle after strobe
  input  wire logic            main_power_good,  // Asynchronous power good pin
  input  wire logic            lock,             // Register lock bit
  input  wire logic            global_int_en,    // Global interrupt enable
  input  wire logic            monitor_cycle,    // One-cycle pulse: new readings valid
  input  wire tzs_pkg::tzs_byte_t zone1_temp,    // Remote diode 1 reading, signed
  input  wire tzs_pkg::tzs_byte_t zone2_temp,    // Ambient reading, signed
  input  wire tzs_pkg::tzs_byte_t zone3_temp,    // Remote diode 2 reading, signed
  input  wire tzs_pkg::tzs_byte_t sec1_set,      // Primary status one set events
  input  wire tzs_pkg::tzs_byte_t sec1_active,   // Status one events still active
  input  wire tzs_pkg::tzs_byte_t sec2_set,      // Primary status two set events
  input  wire tzs_pkg::tzs_byte_t sec2_active,   // Status two events still active
  input  wire tzs_pkg::tzs_byte_t sec3_set,      // Primary status three set events
  input  wire tzs_pkg::tzs_byte_t sec3_active,   // Status three events still active
  output      logic [5:0]      tach_mode,        // Tach 1..3 modes, tach 1 in [5:4]
  output      tzs_pkg::tzs_byte_t zone1_low,     // Zone low limits
  output      tzs_pkg::tzs_byte_t zone2_low,
  output      tzs_pkg::tzs_byte_t zone3_low,
  output      logic            thermal_irq_pin,  // Thermal interrupt, high while asserted
  output      logic            thermal_trip_out_n // Thermal trip, low active
);
  import tzs_pkg::*;

  // ==========================================================
  // Elaboration checks
  // Four minutes must fit the hold counter
  if (MINUTE_CYCLES == 36'h0 || {2'b00, MINUTE_CYCLES} * 38'd4 > 38'h0fffffffff) begin : g_bad_minute
    $error("MINUTE_CYCLES out of range");
  end

  // ==========================================================
  // State
  tzs_state_t s_ff;   // Registered state
  tzs_state_t nxt_s;  // Next state

  tzs_byte_t [2:0] temp;     // Readings as an array
  logic            pg_rise;  // Rising edge of synchronised power good
  logic            wr_ok;    // Write to a lockable register allowed

  assign temp    = {zone3_temp, zone2_temp, zone1_temp};
  assign pg_rise = s_ff.pg_sync[1] & ~s_ff.pg_sync[2];
  assign wr_ok   = reg_wr & ~lock;

  // Step code to degrees: 2, 4, 6, 8
  function automatic logic [8:0] step_deg(input logic [1:0] code);
    step_deg = {6'h00, code, 1'b0} + 9'h002;
  endfunction

  // Delay code to cycles: 1..4 minutes
  function automatic tzs_hold_t dly_cycles(input logic [1:0] code);
    logic [37:0] full;
    full = {2'b00, MINUTE_CYCLES} * {36'h0, code + 2'b00} + {2'b00, MINUTE_CYCLES};
    dly_cycles = full[35:0];
  endfunction

  // ==========================================================
  // Next-state logic
  // Set terms are ORed in after the clears so an event in the clear cycle is kept
  always_comb begin
    logic [8:0] diff;
    logic       over_top;
    logic       reach_top;
    logic       over_trip;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [7:0] clr3;
    logic [2:0] clr_top;
    logic [2:0] clr_trip;
    diff      = 9'h000;
    over_top  = 1'b0;
    reach_top = 1'b0;
    over_trip = 1'b0;
    clr1      = 8'h00;
    clr2      = 8'h00;
    clr3      = 8'h00;
    clr_top   = 3'h0;
    clr_trip  = 3'h0;
    nxt_s     = s_ff;

    // Power good synchroniser; only the second flop feeds edge detect
    nxt_s.pg_sync = {s_ff.pg_sync[1], s_ff.pg_sync[0], main_power_good};

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `TZS_ADDR_SEC1:      clr1 = reg_wdata & `TZS_SEC1_W1C_MASK & ~sec1_active;
        `TZS_ADDR_SEC2:      clr2 = reg_wdata & ~sec2_active;
        `TZS_ADDR_SEC3:      clr3 = reg_wdata & ~sec3_active;
        `TZS_ADDR_TACH:      nxt_s.tach_mode = reg_wdata[7:2];
        `TZS_ADDR_TOP_STAT:  clr_top = reg_wdata[2:0];
        `TZS_ADDR_TRIP_STAT: clr_trip = reg_wdata[2:0] & ~s_ff.trip_pend;
        `TZS_ADDR_LOW1:      nxt_s.low[0] = reg_wdata;
        `TZS_ADDR_LOW2:      nxt_s.low[1] = reg_wdata;
        `TZS_ADDR_LOW3:      nxt_s.low[2] = reg_wdata;
        default: begin
          // Lockable registers take the write only while unlocked
          if (wr_ok) begin
            case (reg_addr)
              `TZS_ADDR_TOP1:      nxt_s.top[0] = reg_wdata;
              `TZS_ADDR_TOP2:      nxt_s.top[1] = reg_wdata;
              `TZS_ADDR_TOP3:      nxt_s.top[2] = reg_wdata;
              `TZS_ADDR_STEP_RMT: begin
                nxt_s.step[0] = reg_wdata[7:6];
                nxt_s.step[2] = reg_wdata[5:4];
              end
              `TZS_ADDR_AMB: begin
                nxt_s.step[1] = reg_wdata[5:4];
                nxt_s.dly[1]  = reg_wdata[1:0];
              end
              `TZS_ADDR_DLY_RMT: begin
                nxt_s.dly[0] = reg_wdata[7:6];
                nxt_s.dly[2] = reg_wdata[5:4];
              end
              `TZS_ADDR_ADJ_EN: begin
                nxt_s.adj_en     = reg_wdata[3:1];
                nxt_s.top_int_en = reg_wdata[`TZS_TOP_INT_EN_BIT];
              end
              `TZS_ADDR_TRIP_CTRL: nxt_s.trip_en = reg_wdata[`TZS_TRIP_EN_BIT];
              `TZS_ADDR_TRIP1:     nxt_s.trip_lim[0] = reg_wdata;
              `TZS_ADDR_TRIP2:     nxt_s.trip_lim[1] = reg_wdata;
              `TZS_ADDR_TRIP3:     nxt_s.trip_lim[2] = reg_wdata;
              `TZS_ADDR_TRIP_OE:   nxt_s.trip_oe = reg_wdata[2:0];
              default: begin
                // Unmapped or read-only: nothing stored
              end
            endcase
          end
        end
      endcase
    end

    // Secondary status: mirror only, they feed no interrupt
    nxt_s.sec1 = (s_ff.sec1 & ~clr1) | sec1_set;
    nxt_s.sec2 = (s_ff.sec2 & ~clr2) | sec2_set;
    nxt_s.sec3 = (s_ff.sec3 & ~clr3) | sec3_set;

    // Per-zone supervision
    for (int i = 0; i < 3; i++) begin
      over_top  = s_ff.adj_en[i] && ($signed(temp[i]) > $signed(s_ff.top[i]));
      reach_top = s_ff.adj_en[i] && ($signed(temp[i]) >= $signed(s_ff.top[i]));
      over_trip = $signed(temp[i]) > $signed(s_ff.trip_lim[i]);

      // Top status: clear only once the zone is no longer over its top
      if (clr_top[i] && !over_top) begin
        nxt_s.top_stat[i] = 1'b0;
      end
      if (monitor_cycle && over_top) begin
        nxt_s.top_stat[i] = 1'b1;
      end

      // Hold-off countdown, then adjust on the next reading at top
      if (s_ff.hold[i] != 36'h0) begin
        nxt_s.hold[i] = s_ff.hold[i] - 36'h1;
      end else if (monitor_cycle && reach_top) begin
        diff = {s_ff.low[i][7], s_ff.low[i]} - step_deg(s_ff.step[i]);
        // Saturate rather than wrap to a high limit
        nxt_s.low[i]  = ($signed(diff) < $signed({1'b1, `TZS_TEMP_FLOOR})) ? `TZS_TEMP_FLOOR : diff[7:0];
        nxt_s.hold[i] = dly_cycles(s_ff.dly[i]);
      end

      // Trip needs two monitoring cycles in a row over the limit
      if (clr_trip[i]) begin
        nxt_s.trip_stat[i] = 1'b0;
      end
      if (monitor_cycle) begin
        nxt_s.trip_pend[i] = over_trip;
        if (over_trip && s_ff.trip_pend[i]) begin
          nxt_s.trip_stat[i] = 1'b1;
        end
      end
    end

    // Power good rise restores status defaults; it outranks everything else
    if (pg_rise) begin
      nxt_s.sec1      = `TZS_RST_BYTE;
      nxt_s.sec2      = `TZS_RST_BYTE;
      nxt_s.sec3      = `TZS_RST_BYTE;
      nxt_s.top_stat  = 3'h0;
      nxt_s.trip_stat = 3'h0;
    end

    // Pins: built from registered status, so they lag the status by one edge
    nxt_s.irq    = s_ff.top_int_en & (|s_ff.top_stat) & global_int_en;
    nxt_s.trip_n = ~(s_ff.trip_en & (|(s_ff.trip_stat & s_ff.trip_oe)));

    // Read data, valid only in the cycle after the strobe
    nxt_s.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TZS_ADDR_SEC1:      nxt_s.rdata = s_ff.sec1;
        `TZS_ADDR_SEC2:      nxt_s.rdata = s_ff.sec2;
        `TZS_ADDR_SEC3:      nxt_s.rdata = s_ff.sec3;
        `TZS_ADDR_TACH:      nxt_s.rdata = {s_ff.tach_mode, 2'b00};
        `TZS_ADDR_TOP1:      nxt_s.rdata = s_ff.top[0];
        `TZS_ADDR_TOP2:      nxt_s.rdata = s_ff.top[1];
        `TZS_ADDR_TOP3:      nxt_s.rdata = s_ff.top[2];
        `TZS_ADDR_STEP_RMT:  nxt_s.rdata = {s_ff.step[0], s_ff.step[2], 4'h0};
        `TZS_ADDR_AMB:       nxt_s.rdata = {2'b00, s_ff.step[1], 2'b00, s_ff.dly[1]};
        `TZS_ADDR_DLY_RMT:   nxt_s.rdata = {s_ff.dly[0], s_ff.dly[2], 4'h0};
        `TZS_ADDR_ADJ_EN:    nxt_s.rdata = {4'h0, s_ff.adj_en, s_ff.top_int_en};
        `TZS_ADDR_TOP_STAT:  nxt_s.rdata = {5'h00, s_ff.top_stat};
        `TZS_ADDR_TRIP_CTRL: nxt_s.rdata = {6'h00, s_ff.trip_en, 1'b0};
        `TZS_ADDR_TRIP1:     nxt_s.rdata = s_ff.trip_lim[0];
        `TZS_ADDR_TRIP2:     nxt_s.rdata = s_ff.trip_lim[1];
        `TZS_ADDR_TRIP3:     nxt_s.rdata = s_ff.trip_lim[2];
        `TZS_ADDR_TRIP_STAT: nxt_s.rdata = {5'h00, s_ff.trip_stat};
        `TZS_ADDR_TRIP_OE:   nxt_s.rdata = {5'h00, s_ff.trip_oe};
        `TZS_ADDR_LOW1:      nxt_s.rdata = s_ff.low[0];
        `TZS_ADDR_LOW2:      nxt_s.rdata = s_ff.low[1];
        `TZS_ADDR_LOW3:      nxt_s.rdata = s_ff.low[2];
        default:             nxt_s.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_ff            <= '0;
      s_ff.top        <= {3{`TZS_RST_TOP}};
      s_ff.trip_lim   <= {3{`TZS_RST_TRIP_LIM}};
      s_ff.low        <= {3{`TZS_RST_LOW}};
      s_ff.trip_n     <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs, straight from flops
  assign reg_rdata          = s_ff.rdata;
  assign tach_mode          = s_ff.tach_mode;
  assign zone1_low          = s_ff.low[0];
  assign zone2_low          = s_ff.low[1];
  assign zone3_low          = s_ff.low[2];
  assign thermal_irq_pin    = s_ff.irq;
  assign thermal_trip_out_n = s_ff.trip_n;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_tach_reserved_zero: assert property (reg_rd && reg_addr == `TZS_ADDR_TACH |=> reg_rdata[1:0] == 2'b00)
    else $error("tach reserved bits not zero");

  chk_lock_blocks_top: assert property (lock && reg_wr && reg_addr == `TZS_ADDR_TOP1 |=> $stable(s_ff.top[0]))
    else $error("top limit written while locked");

  chk_pg_clears_status: assert property (pg_rise && sec1_set == 8'h00 && monitor_cycle == 1'b0
    |=> s_ff.sec1 == 8'h00 && s_ff.top_stat == 3'h0)
    else $error("power good rise left status set");

  chk_irq_needs_global: assert property (!global_int_en |=> !thermal_irq_pin)
    else $error("interrupt without global enable");

  chk_irq_follows_status: assert property (global_int_en && s_ff.top_int_en && s_ff.top_stat != 3'h0
    |=> thermal_irq_pin)
    else $error("interrupt missing");

  chk_trip_two_cycles: assert property ($rose(s_ff.trip_stat[1])
    |-> $past(s_ff.trip_pend[1]) && $past(monitor_cycle))
    else $error("trip status after one cycle");

  chk_trip_pin_enable: assert property (!thermal_trip_out_n
    |-> $past(s_ff.trip_en) && $past(s_ff.trip_stat & s_ff.trip_oe) != 3'h0)
    else $error("trip pin without enable");

  chk_top_status_holds: assert property (s_ff.top_stat[0] && !pg_rise
    && !(reg_wr && reg_addr == `TZS_ADDR_TOP_STAT) |=> s_ff.top_stat[0])
    else $error("top status lost without write");

  chk_top_needs_enable: assert property (!s_ff.adj_en[0] |=> !$rose(s_ff.top_stat[0]))
    else $error("top status set while adjust off");

  chk_floor_saturates: assert property (s_ff.low[0] == `TZS_TEMP_FLOOR && !reg_wr
    |=> s_ff.low[0] == `TZS_TEMP_FLOOR)
    else $error("low limit wrapped below floor");

  chk_hold_blocks_adjust: assert property (s_ff.hold[0] != 36'h0 && !reg_wr |=> $stable(s_ff.low[0]))
    else $error("adjust inside hold-off");

  cov_trip_asserted: cover property (!thermal_trip_out_n);
  cov_adjust_done:   cover property ($changed(s_ff.low[0]) && !$past(reg_wr));
  cov_irq_raised:    cover property ($rose(thermal_irq_pin));

endmodule // tzs_supervisor

// [rtl/tzs_params.svh]
// Register offsets, field positions, reset values and timing for the thermal zone supervisor.
// Assumes an 8-bit register port and a 200 MHz monitor clock.
`ifndef TZS_PARAMS_SVH
`define TZS_PARAMS_SVH

// ==========================================================
// Register offsets
`define TZS_ADDR_SEC1      8'ha5
`define TZS_ADDR_SEC2      8'ha6
`define TZS_ADDR_SEC3      8'ha7
`define TZS_ADDR_TACH      8'hab
`define TZS_ADDR_TOP1      8'hae
`define TZS_ADDR_TOP2      8'haf
`define TZS_ADDR_TOP3      8'hb3
`define TZS_ADDR_STEP_RMT  8'hb4
`define TZS_ADDR_AMB       8'hb5
`define TZS_ADDR_DLY_RMT   8'hb6
`define TZS_ADDR_ADJ_EN    8'hb7
`define TZS_ADDR_TOP_STAT  8'hb8
`define TZS_ADDR_TRIP_CTRL 8'hc1
`define TZS_ADDR_TRIP1     8'hc4
`define TZS_ADDR_TRIP2     8'hc5
`define TZS_ADDR_TRIP3     8'hc9
`define TZS_ADDR_TRIP_STAT 8'hca
`define TZS_ADDR_TRIP_OE   8'hcb
`define TZS_ADDR_LOW1      8'hf0
`define TZS_ADDR_LOW2      8'hf1
`define TZS_ADDR_LOW3      8'hf2

// ==========================================================
// Field positions
`define TZS_SEC1_W1C_MASK  8'h70
`define TZS_TOP_INT_EN_BIT 0
`define TZS_TRIP_EN_BIT    1

// ==========================================================
// Reset values
`define TZS_RST_BYTE       8'h00
`define TZS_RST_TOP        8'h7f
`define TZS_RST_TRIP_LIM   8'h7f
`define TZS_RST_LOW        8'h00
`define TZS_TEMP_FLOOR     8'h80

// ==========================================================
// Timing: one adjust-delay unit is a minute
`define TZS_MINUTE_S       64'd60
`define TZS_CLK_HZ         64'd200000000

`endif

// [rtl/tzs_pkg.sv]
// Types shared by the thermal zone supervisor.
// Assumes tzs_params.svh is compiled alongside.
package tzs_pkg;

  // ==========================================================
  // Whole state of the supervisor, registered in one place
  typedef logic [7:0] tzs_byte_t;
  typedef logic [35:0] tzs_hold_t;

  typedef struct packed {
    logic [2:0]        pg_sync;    // [0] first sync flop, [1] second, [2] previous
    tzs_byte_t         sec1;       // Secondary status copies
    tzs_byte_t         sec2;
    tzs_byte_t         sec3;
    logic [5:0]        tach_mode;  // Three two-bit tach modes
    tzs_byte_t [2:0]   top;        // Top temperature per zone
    tzs_byte_t [2:0]   low;        // Zone low limit
    logic [2:0][1:0]   step;       // Adjust step code
    logic [2:0][1:0]   dly;        // Adjust delay code
    logic [2:0]        adj_en;     // Auto adjust enable
    logic              top_int_en; // Top exceeded interrupt enable
    logic [2:0]        top_stat;   // Top exceeded status
    logic              trip_en;    // Trip output master enable
    tzs_byte_t [2:0]   trip_lim;   // Trip limits
    logic [2:0]        trip_oe;    // Per-zone trip output enable
    logic [2:0]        trip_stat;  // Trip status
    logic [2:0]        trip_pend;  // Exceeded on the last monitoring cycle
    tzs_hold_t [2:0]   hold;       // Adjust hold-off counters
    tzs_byte_t         rdata;      // Read data
    logic              irq;        // Thermal interrupt level
    logic              trip_n;     // Trip output, low active
  } tzs_state_t;

endpackage : tzs_pkg

// [verif/tb.sv]
// Self-checking bench for the thermal zone supervisor: registers, status, adjust and trip.
// Assumes tzs_pkg and tzs_params.svh are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`include "tzs_params.svh"

module tb;
  import tzs_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  localparam int MIN_CYC = 20;               // Shortened minute so hold-offs stay brief
  logic       clock = 0;                     // 200 MHz clock
  logic       nrst = 0;                      // Synchronous reset, low active
  logic       reg_wr = 0;                    // Write strobe
  logic       reg_rd = 0;                    // Read strobe
  logic       main_power_good = 1;           // Power good pin
  logic       lock = 0;                      // Register lock
  logic       global_int_en = 0;             // Global interrupt enable
  logic       monitor_cycle = 0;             // New readings pulse
  tzs_byte_t  reg_addr = 0;                  // Register address
  tzs_byte_t  reg_wdata = 0;                 // Write data
  tzs_byte_t  z1 = 0, z2 = 0, z3 = 0;        // Zone readings
  tzs_byte_t  sset[3] = '{0, 0, 0};          // Secondary status set events
  tzs_byte_t  sact[3] = '{0, 0, 0};          // Secondary events still active
  tzs_byte_t  reg_rdata, low1, low2, low3;   // Observed bytes
  logic [5:0] tach_mode;                     // Observed tach modes
  logic       irq, trip_n;                   // Observed pins
  tzs_byte_t  v;                             // Read-back scratch
  int         err_count = 0;                 // Mismatches seen
  int         checks_done = 0;               // Comparisons made

  tzs_supervisor #(.MINUTE_CYCLES(36'(MIN_CYC))) tzs_supervisor_inst (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_power_good(main_power_good), .lock(lock),
    .global_int_en(global_int_en), .monitor_cycle(monitor_cycle), .zone1_temp(z1), .zone2_temp(z2),
    .zone3_temp(z3), .sec1_set(sset[0]), .sec1_active(sact[0]), .sec2_set(sset[1]),
    .sec2_active(sact[1]), .sec3_set(sset[2]), .sec3_active(sact[2]), .tach_mode(tach_mode),
    .zone1_low(low1), .zone2_low(low2), .zone3_low(low3), .thermal_irq_pin(irq),
    .thermal_trip_out_n(trip_n));

  // ==========================================================
  // Clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write; strobe released at the next edge
  task automatic wr(input tzs_byte_t a, input tzs_byte_t d);
    @(posedge clock);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input tzs_byte_t a, output tzs_byte_t d);
    @(posedge clock);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input string nm, input tzs_byte_t a, input tzs_byte_t exp);
    tzs_byte_t d;
    rd(a, d);
    chk(nm, d, exp);
  endtask

  // One monitoring pulse; readings keep their value afterwards for live compares
  task automatic mon(input tzs_byte_t a, input tzs_byte_t b, input tzs_byte_t c);
    @(posedge clock);
    z1 <= a;
    z2 <= b;
    z3 <= c;
    monitor_cycle <= 1;
    @(posedge clock);
    monitor_cycle <= 0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Model of one adjustment: signed subtract that stops at the lowest value
  function automatic tzs_byte_t sat_sub(input int low, input int code);
    int r;
    r = (low > 127 ? low - 256 : low) - 2 * (code + 1);
    if (r < -128) r = -128;
    return tzs_byte_t'(r);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the run needs a few thousand cycles at most
  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'he0b13836));
    repeat (16) @(posedge clock);
    nrst <= 1;
    rchk("top1 reset", `TZS_ADDR_TOP1, `TZS_RST_TOP);
    rchk("trip1 reset", `TZS_ADDR_TRIP1, `TZS_RST_TRIP_LIM);
    rchk("unmapped", 8'h00, 8'h00);
    $display("test reset done");

    // Every mode code in every tach field, then a random byte; low pair always reads zero
    for (int k = 0; k < 5; k++) begin
      v = (k < 4) ? {k[1:0], k[1:0], k[1:0], 2'b11} : tzs_byte_t'($urandom);
      wr(`TZS_ADDR_TACH, v);
      rchk("tach reg", `TZS_ADDR_TACH, {v[7:2], 2'b00});
      chk("tach port", {2'b00, tach_mode}, {2'b00, v[7:2]});
    end
    $display("test tach done");

    // Secondary status: held while active, zero-writes ignored, no interrupt with both enables on
    wr(`TZS_ADDR_ADJ_EN, 8'h01);
    global_int_en <= 1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      sset[i] <= 8'h10;
      sact[i] <= 8'h10;
      @(posedge clock);
      sset[i] <= 8'h00;
      wr(`TZS_ADDR_SEC1 + 8'(i), 8'h10);
      rchk("sec active", `TZS_ADDR_SEC1 + 8'(i), 8'h10);
      @(posedge clock);
      sact[i] <= 8'h00;
      wr(`TZS_ADDR_SEC1 + 8'(i), 8'h00);
      rchk("sec zero wr", `TZS_ADDR_SEC1 + 8'(i), 8'h10);
      chk("sec no irq", {7'h0, irq}, 8'h00);
      wr(`TZS_ADDR_SEC1 + 8'(i), 8'h10);
      rchk("sec cleared", `TZS_ADDR_SEC1 + 8'(i), 8'h00);
    end
    $display("test secondary done");

    // Auto adjust on zone 1 only; zone 3 over its top but not enabled
    wr(`TZS_ADDR_LOW1, 8'h40);
    wr(`TZS_ADDR_LOW3, 8'h40);
    wr(`TZS_ADDR_TOP1, 8'h20);
    wr(`TZS_ADDR_TOP3, 8'h10);
    wr(`TZS_ADDR_STEP_RMT, 8'h40);
    wr(`TZS_ADDR_DLY_RMT, 8'h00);
    wr(`TZS_ADDR_ADJ_EN, 8'h03);
    mon(8'h30, 8'h00, 8'h30);
    chk("low1 adj", low1, sat_sub(8'h40, 1));
    chk("low3 off", low3, 8'h40);
    rchk("top stat", `TZS_ADDR_TOP_STAT, 8'h01);
    chk("irq on", {7'h0, irq}, 8'h01);
    mon(8'h30, 8'h00, 8'h00);
    chk("low1 hold", low1, sat_sub(8'h40, 1));
    repeat (MIN_CYC + 4) @(posedge clock);
    mon(8'h30, 8'h00, 8'h00);
    chk("low1 again", low1, sat_sub(sat_sub(8'h40, 1), 1));
    wr(`TZS_ADDR_TOP_STAT, 8'h01);
    rchk("top stay", `TZS_ADDR_TOP_STAT, 8'h01);
    @(posedge clock);
    z1 <= 8'h00;
    wr(`TZS_ADDR_TOP_STAT, 8'h01);
    rchk("top clr", `TZS_ADDR_TOP_STAT, 8'h00);
    repeat (2) @(posedge clock);
    #1 chk("irq off", {7'h0, irq}, 8'h00);
    repeat (MIN_CYC + 4) @(posedge clock);
    wr(`TZS_ADDR_LOW1, 8'h82);
    wr(`TZS_ADDR_STEP_RMT, 8'hc0);
    mon(8'h30, 8'h00, 8'h00);
    chk("low1 floor", low1, sat_sub(8'h82, 3));
    $display("test adjust done");

    // Ambient zone: step 6 and a 4-minute delay from its own register; reaching top is not exceeding
    wr(`TZS_ADDR_AMB, 8'h23);
    rchk("amb reg", `TZS_ADDR_AMB, 8'h23);
    wr(`TZS_ADDR_TOP2, 8'h10);
    wr(`TZS_ADDR_LOW2, 8'h20);
    wr(`TZS_ADDR_ADJ_EN, 8'h05);
    mon(8'h00, 8'h10, 8'h00);
    chk("low2 adj", low2, sat_sub(8'h20, 2));
    repeat (3 * MIN_CYC) @(posedge clock);
    mon(8'h00, 8'h10, 8'h00);
    chk("low2 hold", low2, sat_sub(8'h20, 2));
    rchk("top reach", `TZS_ADDR_TOP_STAT, 8'h01);
    wr(`TZS_ADDR_ADJ_EN, 8'h03);
    $display("test ambient done");

    // Lock blocks top and trip limit writes
    @(posedge clock);
    lock <= 1;
    wr(`TZS_ADDR_TOP1, 8'h55);
    wr(`TZS_ADDR_TRIP2, 8'h55);
    lock <= 0;
    rchk("lock top", `TZS_ADDR_TOP1, 8'h20);
    rchk("lock trip", `TZS_ADDR_TRIP2, `TZS_RST_TRIP_LIM);
    $display("test lock done");

    // Trip on zone 2 needs two monitoring cycles over its own limit
    wr(`TZS_ADDR_TRIP2, 8'h10);
    wr(`TZS_ADDR_TRIP_OE, 8'h02);
    wr(`TZS_ADDR_TRIP_CTRL, 8'h02);
    mon(8'h00, 8'h20, 8'h00);
    rchk("trip one", `TZS_ADDR_TRIP_STAT, 8'h00);
    chk("trip_n one", {7'h0, trip_n}, 8'h01);
    mon(8'h00, 8'h20, 8'h00);
    rchk("trip two", `TZS_ADDR_TRIP_STAT, 8'h02);
    chk("trip_n two", {7'h0, trip_n}, 8'h00);
    wr(`TZS_ADDR_TRIP_CTRL, 8'h00);
    @(posedge clock);
    #1 chk("trip_n off", {7'h0, trip_n}, 8'h01);
    wr(`TZS_ADDR_TRIP_STAT, 8'h02);
    rchk("trip stay", `TZS_ADDR_TRIP_STAT, 8'h02);
    mon(8'h00, 8'h00, 8'h00);
    wr(`TZS_ADDR_TRIP_STAT, 8'h02);
    rchk("trip clr", `TZS_ADDR_TRIP_STAT, 8'h00);
    $display("test trip done");

    // Power good rise clears top status and secondary status
    @(posedge clock);
    sset[2] <= 8'h01;
    @(posedge clock);
    sset[2] <= 8'h00;
    repeat (MIN_CYC + 4) @(posedge clock);
    mon(8'h30, 8'h00, 8'h00);
    rchk("pre pg", `TZS_ADDR_TOP_STAT, 8'h01);
    @(posedge clock);
    main_power_good <= 0;
    repeat (4) @(posedge clock);
    main_power_good <= 1;
    z1 <= 8'h00;
    repeat (6) @(posedge clock);
    rchk("pg sec3", `TZS_ADDR_SEC3, 8'h00);
    rchk("pg top", `TZS_ADDR_TOP_STAT, 8'h00);
    $display("test power good done");
    summarize();
  end
endmodule // tb
